// >>> include/tsctl_pkg.sv
// Purpose: constants and types of the timestamp counter control block
// Assumes: 250 MHz system clock, 32-bit register bus
// Notes: register offsets are byte addresses of aligned words
package tsctl_pkg;

  // ****************************************************************
  // clock and tick rates
  // ****************************************************************
  localparam logic [31:0] CLK_HZ = 32'h0EE6B280;   // 250 MHz
  localparam logic [31:0] TICK_LOCAL = CLK_HZ;     // one tick per clock
  localparam logic [31:0] TICK_PTP = 32'h3B9ACA00; // 1588 time in ns

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_TICK = 8'h0C;
  localparam logic [7:0] OFF_CAPT_LO = 8'h10;
  localparam logic [7:0] OFF_CAPT_HI = 8'h14;
  localparam logic [7:0] OFF_EVT_CHOICE = 8'h18;
  localparam logic [7:0] OFF_NOTIFY = 8'h1C;
  localparam logic [7:0] OFF_DEV_KEY = 8'h20;
  localparam logic [7:0] OFF_GRP_KEY1 = 8'h24;
  localparam logic [7:0] OFF_GRP_MASK1 = 8'h28;
  localparam logic [7:0] OFF_GRP_KEY2 = 8'h2C;
  localparam logic [7:0] OFF_GRP_MASK2 = 8'h30;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CMD_LATCH = 0;
  localparam int CMD_CLEAR = 1;
  localparam int CFG_TBASE = 0;
  localparam int CFG_PTP = 1;
  localparam int CFG_CLRSRC = 2;
  localparam int CFG_CLREDGE = 4;
  localparam int CFG_CAPT = 6;
  localparam int CFG_TSEL = 8;
  localparam int CFG_TSRC = 12;
  localparam int CFG_SLAVE = 14;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] KEY_RESET = 32'h00000000;
  localparam logic [63:0] COUNT_RESET = 64'h0000000000000000;

  // ****************************************************************
  // enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    CLR_NONE = 2'h0,
    CLR_PIN_ONE = 2'h1,
    CLR_PIN_TWO = 2'h2,
    CLR_ACTION_TWO = 2'h3
  } tsctl_clr_src_e;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2
  } tsctl_edge_e;

  localparam logic [2:0] TSEL_SINGLE = 3'h0;
  localparam logic [2:0] TSEL_MULTI = 3'h1;
  localparam logic [2:0] TSEL_ACQ = 3'h2;

  localparam logic [1:0] TSRC_NONE = 2'h0;
  localparam logic [1:0] TSRC_ACT_ONE = 2'h1;
  localparam logic [1:0] TSRC_ACT_TWO = 2'h2;

endpackage

// >>> rtl/tsctl_clear_edge.sv
// Purpose: hardware clear source select and edge detection
// Assumes: pins synchronous to CLK
// Notes: action two is already a one-cycle pulse, used as the event
`timescale 1ns/1ns
`default_nettype none
module tsctl_clear_edge
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_one,
  input wire logic pin_two,
  input wire logic action_two,
  input wire logic [1:0] clear_trigger_select,
  input wire logic [1:0] clear_edge_polarity,
  output logic clear_pulse
);
  logic [1:0] pin;
  logic [1:0] prev;
  logic [1:0] hit;

  assign pin = {pin_two, pin_one};

  // ****************************************************************
  // per pin edge detect
  // ****************************************************************
  // both pins are tracked so a select change makes no false edge
  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    always_ff @(posedge clk)
    begin
      if (rst)
        prev[i] <= 1'b0;
      else
        prev[i] <= pin[i];
    end
    always_comb
    begin
      unique case (clear_edge_polarity)
        tsctl_pkg::EDGE_FALL: hit[i] = prev[i] & ~pin[i];
        tsctl_pkg::EDGE_RISE: hit[i] = ~prev[i] & pin[i];
        default: hit[i] = prev[i] ^ pin[i];
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      clear_pulse <= 1'b0;
    else
      unique case (clear_trigger_select)
        tsctl_pkg::CLR_PIN_ONE: clear_pulse <= hit[0];
        tsctl_pkg::CLR_PIN_TWO: clear_pulse <= hit[1];
        tsctl_pkg::CLR_ACTION_TWO: clear_pulse <= action_two;
        default: clear_pulse <= 1'b0;
      endcase
  end

  rise_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    (clear_trigger_select == tsctl_pkg::CLR_PIN_ONE &&
     clear_edge_polarity == tsctl_pkg::EDGE_RISE &&
     !prev[0] && pin_one) |=> clear_pulse)
    else $error("rising edge on pin one did not clear");

  both_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    (clear_trigger_select == tsctl_pkg::CLR_PIN_TWO &&
     clear_edge_polarity == tsctl_pkg::EDGE_BOTH &&
     $changed(pin_two)) |=> clear_pulse)
    else $error("edge on pin two did not clear");
endmodule // tsctl_clear_edge
`default_nettype wire

// >>> rtl/tsctl_action_match.sv
// Purpose: acceptance of broadcast action command packets
// Assumes: packet fields valid for one cycle with pkt_valid
// Notes: one pulse per accepted packet per action
`timescale 1ns/1ns
`default_nettype none
module tsctl_action_match
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pkt_valid,
  input wire logic [31:0] pkt_device_key,
  input wire logic [31:0] pkt_group_key,
  input wire logic [31:0] pkt_group_mask,
  input wire logic [1:0] slave_enable,
  input wire logic [31:0] device_key,
  input wire logic [63:0] group_key,
  input wire logic [63:0] group_mask,
  output logic [1:0] action_pulse
);
  logic [1:0] match;

  for (genvar i = 0; i < 2; i++)
  begin : g_act
    assign match[i] = pkt_valid && slave_enable[i] &&
      pkt_device_key == device_key &&
      pkt_group_key == group_key[32*i +: 32] &&
      (pkt_group_mask & group_mask[32*i +: 32]) != 32'h00000000;
    always_ff @(posedge clk)
    begin
      if (rst)
        action_pulse[i] <= 1'b0;
      else
        action_pulse[i] <= match[i];
    end
  end

  action_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    match[0] |=> action_pulse[0])
    else $error("matching packet gave no action pulse");

  no_stray_a: assert property (
    @(posedge clk) disable iff (rst)
    !pkt_valid |=> action_pulse == 2'h0)
    else $error("action pulse without a packet");
endmodule // tsctl_action_match
`default_nettype wire

// >>> rtl/tsctl_top.sv
// Purpose: 64-bit timestamp counter with latch, clear and action logic
// Assumes: Avalon-MM slave, one wait cycle per access
// Notes: local base counts CLK, 1588 base counts PTP_TICK
//
// How it works
// - action one trigger needs single, multi, acquisition
// - action two trigger needs acquisition start selector
// - latch command copies counter into captured value
// - captured value is 64 bits, selected base
// - local base increments from internal clock
// - enabling 1588 mode forces 1588 time base
// - tick rate report follows selected time base
// - frame begin latches counter when selected
// - clear command sets counter to zero, except while 1588 mode is on
// - clear command zeroes local counter, and 1588 counter only with 1588 mode off
// - software clear works with no source selected
// - action two may clear counter too
// - edge polarity picks falling or rising clear
// - both edges setting clears on every transition
// - event choice picks what notify enable controls
// - matching action packet gives one action pulse
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module tsctl_top
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic INPUT_PIN_ONE,
  input wire logic INPUT_PIN_TWO,
  input wire logic FRAME_BEGIN,
  input wire logic PTP_TICK,
  input wire logic ACT_PKT_VALID,
  input wire logic [31:0] ACT_DEVICE_KEY,
  input wire logic [31:0] ACT_GROUP_KEY,
  input wire logic [31:0] ACT_GROUP_MASK,
  output logic [63:0] TIMESTAMP,
  output logic [1:0] ACTION_PULSE,
  output logic TRIGGER_ACTION,
  output logic [15:0] NOTIFY_ENABLE,
  output logic PTP_BASE_ACTIVE
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic ack;
  logic wr_fire;
  logic rd_take;
  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic [31:0] merged;
  logic [3:0] event_choice;
  logic [31:0] device_key;
  logic [63:0] group_key;
  logic [63:0] group_mask;
  logic [63:0] local_cnt;
  logic [63:0] ptp_cnt;
  logic [63:0] cur_count;
  logic [63:0] captured_time_value;
  logic [31:0] tick_rate_report;
  logic [31:0] rd_mux;
  logic latch_now_cmd;
  logic clear_time_cmd;
  logic hw_clear;
  logic clr_any;
  logic latch_any;
  logic ptp_mode;
  logic ptp_active;
  logic capture_trigger_select;
  logic [2:0] trig_sel;
  logic [1:0] trig_src;
  logic [1:0] act;

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  function automatic logic src_ok(input logic [1:0] src,
    input logic [2:0] sel);
    logic ok;
    ok = 1'b1;
    if (src == tsctl_pkg::TSRC_ACT_ONE)
      ok = sel == tsctl_pkg::TSEL_SINGLE || sel == tsctl_pkg::TSEL_MULTI ||
        sel == tsctl_pkg::TSEL_ACQ;
    else if (src == tsctl_pkg::TSRC_ACT_TWO)
      ok = sel == tsctl_pkg::TSEL_ACQ;
    return ok;
  endfunction

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // first cycle of a request waits, second completes it
  always_ff @(posedge CLK)
  begin
    if (RST)
      ack <= 1'b0;
    else
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
  end

  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
  assign wr_fire = AVS_WRITE & ack;
  assign rd_take = AVS_READ & ~ack;
  assign merged = merge(cfg, AVS_WRITEDATA, AVS_BYTEENABLE);

  // ****************************************************************
  // configuration
  // ****************************************************************
  assign ptp_mode = cfg[tsctl_pkg::CFG_PTP];
  assign capture_trigger_select = cfg[tsctl_pkg::CFG_CAPT];
  assign trig_sel = cfg[tsctl_pkg::CFG_TSEL +: 3];
  assign trig_src = cfg[tsctl_pkg::CFG_TSRC +: 2];

  always_comb
  begin
    next_cfg = merged;
    // switching 1588 on drags the time base along
    if (merged[tsctl_pkg::CFG_PTP])
      next_cfg[tsctl_pkg::CFG_TBASE] = 1'b1;
    // an action source is refused under a selector that forbids it
    if (!src_ok(merged[tsctl_pkg::CFG_TSRC +: 2],
      merged[tsctl_pkg::CFG_TSEL +: 3]))
      next_cfg[tsctl_pkg::CFG_TSRC +: 2] =
        src_ok(trig_src, merged[tsctl_pkg::CFG_TSEL +: 3]) ?
        trig_src : tsctl_pkg::TSRC_NONE;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      cfg <= tsctl_pkg::CFG_RESET;
    else if (wr_fire && AVS_ADDRESS == tsctl_pkg::OFF_CFG)
      cfg <= next_cfg;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      device_key <= tsctl_pkg::KEY_RESET;
      group_key <= {2{tsctl_pkg::KEY_RESET}};
      group_mask <= {2{tsctl_pkg::KEY_RESET}};
    end
    else if (wr_fire)
      unique case (AVS_ADDRESS)
        tsctl_pkg::OFF_DEV_KEY: device_key <=
          merge(device_key, AVS_WRITEDATA, AVS_BYTEENABLE);
        tsctl_pkg::OFF_GRP_KEY1: group_key[31:0] <=
          merge(group_key[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
        tsctl_pkg::OFF_GRP_MASK1: group_mask[31:0] <=
          merge(group_mask[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
        tsctl_pkg::OFF_GRP_KEY2: group_key[63:32] <=
          merge(group_key[63:32], AVS_WRITEDATA, AVS_BYTEENABLE);
        tsctl_pkg::OFF_GRP_MASK2: group_mask[63:32] <=
          merge(group_mask[63:32], AVS_WRITEDATA, AVS_BYTEENABLE);
        default: ;
      endcase
  end

  // ****************************************************************
  // event notification
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
      event_choice <= 4'h0;
    else if (wr_fire && AVS_ADDRESS == tsctl_pkg::OFF_EVT_CHOICE &&
      AVS_BYTEENABLE[0])
      event_choice <= AVS_WRITEDATA[3:0];
  end

  // the enable written lands on the event picked by event_choice
  always_ff @(posedge CLK)
  begin
    if (RST)
      NOTIFY_ENABLE <= 16'h0000;
    else if (wr_fire && AVS_ADDRESS == tsctl_pkg::OFF_NOTIFY &&
      AVS_BYTEENABLE[0])
      NOTIFY_ENABLE[event_choice] <= AVS_WRITEDATA[0];
  end

  // ****************************************************************
  // commands and clear sources
  // ****************************************************************
  assign latch_now_cmd = wr_fire && AVS_ADDRESS == tsctl_pkg::OFF_CMD &&
    AVS_BYTEENABLE[0] && AVS_WRITEDATA[tsctl_pkg::CMD_LATCH];
  // software clear stands apart from the hardware source select
  assign clear_time_cmd = wr_fire && AVS_ADDRESS == tsctl_pkg::OFF_CMD &&
    AVS_BYTEENABLE[0] && AVS_WRITEDATA[tsctl_pkg::CMD_CLEAR];

  tsctl_clear_edge u_clear
  (
    .clk(CLK),
    .rst(RST),
    .pin_one(INPUT_PIN_ONE),
    .pin_two(INPUT_PIN_TWO),
    .action_two(act[1]),
    .clear_trigger_select(cfg[tsctl_pkg::CFG_CLRSRC +: 2]),
    .clear_edge_polarity(cfg[tsctl_pkg::CFG_CLREDGE +: 2]),
    .clear_pulse(hw_clear)
  );

  tsctl_action_match u_action
  (
    .clk(CLK),
    .rst(RST),
    .pkt_valid(ACT_PKT_VALID),
    .pkt_device_key(ACT_DEVICE_KEY),
    .pkt_group_key(ACT_GROUP_KEY),
    .pkt_group_mask(ACT_GROUP_MASK),
    .slave_enable(cfg[tsctl_pkg::CFG_SLAVE +: 2]),
    .device_key(device_key),
    .group_key(group_key),
    .group_mask(group_mask),
    .action_pulse(act)
  );

  assign ACTION_PULSE = act;
  // action commands may serve several functions at once
  assign TRIGGER_ACTION = (trig_src == tsctl_pkg::TSRC_ACT_ONE && act[0]) ||
    (trig_src == tsctl_pkg::TSRC_ACT_TWO && act[1]);

  assign clr_any = clear_time_cmd | hw_clear;
  assign latch_any = latch_now_cmd |
    (capture_trigger_select & FRAME_BEGIN);

  // ****************************************************************
  // counters
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
      local_cnt <= tsctl_pkg::COUNT_RESET;
    else if (clr_any)
      local_cnt <= tsctl_pkg::COUNT_RESET;
    else
      local_cnt <= local_cnt + 64'h1;
  end

  // while 1588 mode runs the network owns this count
  always_ff @(posedge CLK)
  begin
    if (RST)
      ptp_cnt <= tsctl_pkg::COUNT_RESET;
    else if (clr_any && !ptp_mode)
      ptp_cnt <= tsctl_pkg::COUNT_RESET;
    else if (PTP_TICK)
      ptp_cnt <= ptp_cnt + 64'h1;
  end

  assign ptp_active = ptp_mode | cfg[tsctl_pkg::CFG_TBASE];
  assign PTP_BASE_ACTIVE = ptp_active;
  assign cur_count = ptp_active ? ptp_cnt : local_cnt;
  assign TIMESTAMP = cur_count;
  assign tick_rate_report = ptp_active ? tsctl_pkg::TICK_PTP :
    tsctl_pkg::TICK_LOCAL;

  // old count is sampled, so a same-cycle clear loses nothing
  always_ff @(posedge CLK)
  begin
    if (RST)
      captured_time_value <= tsctl_pkg::COUNT_RESET;
    else if (latch_any)
      captured_time_value <= cur_count;
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb
  begin
    unique case (AVS_ADDRESS)
      tsctl_pkg::OFF_CFG: rd_mux = cfg;
      tsctl_pkg::OFF_STATUS: rd_mux = {31'h00000000, ptp_active};
      tsctl_pkg::OFF_TICK: rd_mux = tick_rate_report;
      tsctl_pkg::OFF_CAPT_LO: rd_mux = captured_time_value[31:0];
      tsctl_pkg::OFF_CAPT_HI: rd_mux = captured_time_value[63:32];
      tsctl_pkg::OFF_EVT_CHOICE: rd_mux = {28'h0000000, event_choice};
      tsctl_pkg::OFF_NOTIFY:
        rd_mux = {31'h00000000, NOTIFY_ENABLE[event_choice]};
      tsctl_pkg::OFF_DEV_KEY: rd_mux = device_key;
      tsctl_pkg::OFF_GRP_KEY1: rd_mux = group_key[31:0];
      tsctl_pkg::OFF_GRP_MASK1: rd_mux = group_mask[31:0];
      tsctl_pkg::OFF_GRP_KEY2: rd_mux = group_key[63:32];
      tsctl_pkg::OFF_GRP_MASK2: rd_mux = group_mask[63:32];
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      AVS_READDATA <= 32'h00000000;
    else if (rd_take)
      AVS_READDATA <= rd_mux;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  latch_copy_a: assert property (
    latch_now_cmd |=> captured_time_value == $past(cur_count))
    else $error("latch did not copy the counter");
  frame_latch_a: assert property (
    capture_trigger_select && FRAME_BEGIN |=>
    captured_time_value == $past(cur_count))
    else $error("frame begin did not latch");
  clear_zero_a: assert property (
    clear_time_cmd |=> local_cnt == 64'h0 ##1 local_cnt == 64'h1)
    else $error("clear did not zero the local counter");
  clear_both_a: assert property (
    clr_any && !ptp_mode |=> ptp_cnt == 64'h0)
    else $error("clear did not zero the 1588 counter");
  local_inc_a: assert property (
    !RST && !clr_any |=> local_cnt == $past(local_cnt) + 64'h1)
    else $error("local counter did not advance");
  ptp_base_a: assert property (
    ptp_mode |-> ptp_active && TIMESTAMP == ptp_cnt)
    else $error("1588 mode did not select 1588 base");
  tick_rate_a: assert property (
    tick_rate_report == (cfg[tsctl_pkg::CFG_TBASE] ? tsctl_pkg::TICK_PTP :
    tsctl_pkg::TICK_LOCAL))
    else $error("tick rate does not follow the base");
  act_one_gate_a: assert property (
    trig_src == tsctl_pkg::TSRC_ACT_ONE |-> trig_sel <= tsctl_pkg::TSEL_ACQ)
    else $error("action one under a wrong selector");
  act_two_gate_a: assert property (
    trig_src == tsctl_pkg::TSRC_ACT_TWO |-> trig_sel == tsctl_pkg::TSEL_ACQ)
    else $error("action two under a wrong selector");
  latch_clear_a: assert property (
    latch_any && clr_any |=> captured_time_value == $past(cur_count) &&
    local_cnt == 64'h0)
    else $error("latch with clear lost the old value");
  hw_clear_a: assert property (
    cfg[tsctl_pkg::CFG_CLRSRC +: 2] == tsctl_pkg::CLR_ACTION_TWO &&
    act[1] |=> ##1 local_cnt == 64'h0)
    else $error("action two did not clear the counter");
endmodule // tsctl_top
`default_nettype wire

// >>> verification/tsctl_act_host.sv
// Purpose: far side model sending broadcast action packets
// Assumes: send is a one-cycle request from the bench
// Notes: key lines scramble between packets
`timescale 1ns/1ns
`default_nettype none
module tsctl_act_host
(
  input wire logic clk,
  input wire logic send,
  input wire logic [31:0] dev_key,
  input wire logic [31:0] grp_key,
  input wire logic [31:0] grp_mask,
  output logic pkt_valid,
  output logic [31:0] pkt_dev,
  output logic [31:0] pkt_grp,
  output logic [31:0] pkt_msk
);
  // ****
  // packet launch
  // ****
  // one packet, one cycle, seen by every listener
  always @(posedge clk)
  begin
    pkt_valid <= send;
    // stale keys must not look valid
    pkt_dev <= send ? dev_key : ~dev_key;
    pkt_grp <= send ? grp_key : ~grp_key;
    pkt_msk <= send ? grp_mask : ~grp_mask;
  end
endmodule // tsctl_act_host
`default_nettype wire

// >>> verification/tsctl_top_tb.sv
// Purpose: bench of the timestamp counter control block
// Assumes: bus answers after one wait cycle
// Notes: inputs change by non-blocking assignment on rising edges
`timescale 1ns/1ns
`default_nettype none
module tsctl_top_tb;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic p1 = 1'b0, p2 = 1'b0, fb = 1'b0, pt = 1'b0, send = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, kd = 32'h0, kg = 32'h0, km = 32'h0;
  logic [31:0] rdata, rdat, pdk, pgk, pgm;
  logic wreq, pv, trig, ptpact;
  logic [63:0] ts, last_ts, t0;
  logic [1:0] apulse;
  logic [15:0] nen;
  int fails = 0, checks_done = 0, n_act1 = 0, n_act2 = 0, n_trig = 0;

  tsctl_top tsctl_top_inst (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .INPUT_PIN_ONE(p1), .INPUT_PIN_TWO(p2), .FRAME_BEGIN(fb),
    .PTP_TICK(pt), .ACT_PKT_VALID(pv), .ACT_DEVICE_KEY(pdk),
    .ACT_GROUP_KEY(pgk), .ACT_GROUP_MASK(pgm), .TIMESTAMP(ts),
    .ACTION_PULSE(apulse), .TRIGGER_ACTION(trig), .NOTIFY_ENABLE(nen),
    .PTP_BASE_ACTIVE(ptpact));
  tsctl_act_host tsctl_act_host_inst (.clk(clk), .send(send),
    .dev_key(kd), .grp_key(kg), .grp_mask(km), .pkt_valid(pv),
    .pkt_dev(pdk), .pkt_grp(pgk), .pkt_msk(pgm));

  // ****
  // helpers
  // ****
  initial forever #2 clk = ~clk;
  always @(negedge clk)
  begin
    if (apulse[0] === 1'b1) n_act1++;
    if (apulse[1] === 1'b1) n_act2++;
    if (trig === 1'b1) n_trig++;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // read data and counter taken in the completing cycle
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    while (!done)
    begin
      @(negedge clk);
      done = (wreq === 1'b0);
      rdat = rdata;
      last_ts = ts;
      @(posedge clk);
      n++;
      if (n > 20)
      begin
        fails++;
        $display("CHECK FAILED at %0t: bus timeout", $time);
        report_and_stop();
      end
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task pkt(input logic [31:0] dk, input logic [31:0] gm);
    @(posedge clk);
    kd <= dk;
    kg <= 32'h00000010;
    km <= gm;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (8) @(negedge clk);
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(tsctl_pkg::OFF_CFG, tsctl_pkg::CFG_RESET);
    rchk(tsctl_pkg::OFF_TICK, tsctl_pkg::TICK_LOCAL);
    bus(1'b1, 8'hFC, 32'hFFFFFFFF);
    rchk(8'hFC, 32'h0);
    @(negedge clk) t0 = ts;
    repeat (10) @(negedge clk);
    chk(ts - t0, 64'hA);
    bus(1'b1, tsctl_pkg::OFF_CMD, 32'h1);
    t0 = last_ts;
    repeat (9) rchk(tsctl_pkg::OFF_CAPT_LO, t0[31:0]);
    rchk(tsctl_pkg::OFF_CAPT_HI, t0[63:32]);
    bus(1'b1, tsctl_pkg::OFF_CMD, 32'h2);
    repeat (2) @(negedge clk);
    chk(ts < 4, 1'b1);
    repeat (50) @(posedge clk);
    bus(1'b1, tsctl_pkg::OFF_CMD, 32'h3);
    t0 = last_ts;
    repeat (2) @(negedge clk);
    chk(ts < 4, 1'b1);
    rchk(tsctl_pkg::OFF_CAPT_LO, t0[31:0]);
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h40);
    repeat (2)
    begin
      repeat (7) @(posedge clk);
      fb <= 1'b1;
      @(negedge clk) t0 = ts;
      @(posedge clk) fb <= 1'b0;
      rchk(tsctl_pkg::OFF_CAPT_LO, t0[31:0]);
    end
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h2);
    rchk(tsctl_pkg::OFF_CFG, 32'h3);
    rchk(tsctl_pkg::OFF_STATUS, 32'h1);
    chk(ptpact, 1'b1);
    rchk(tsctl_pkg::OFF_TICK, tsctl_pkg::TICK_PTP);
    @(negedge clk) t0 = ts;
    repeat (5)
    begin
      @(posedge clk) pt <= 1'b1;
      @(posedge clk) pt <= 1'b0;
    end
    @(negedge clk) chk(ts - t0, 64'h5);
    bus(1'b1, tsctl_pkg::OFF_CMD, 32'h2);
    repeat (3) @(negedge clk);
    chk(ts, t0 + 64'h5);
    // mode off before clearing the 1588 count
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h1);
    bus(1'b1, tsctl_pkg::OFF_CMD, 32'h2);
    repeat (3) @(negedge clk);
    chk(ts, 64'h0);
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h0);
    @(negedge clk) chk(ts < 20, 1'b1);
    rchk(tsctl_pkg::OFF_TICK, tsctl_pkg::TICK_LOCAL);
    for (int s = 0; s < 3; s++)
      for (int e = 0; e < 4; e++)
      begin
        bus(1'b1, tsctl_pkg::OFF_CFG, 32'((e << 4) | (s << 2)));
        for (int v = 1; v >= 0; v--)
        begin
          repeat (30) @(posedge clk);
          if (s == 2) p2 <= v[0];
          else p1 <= v[0];
          repeat (6) @(negedge clk);
          chk(ts < 8, s != 0 && (e >= 2 || e == v));
        end
      end
    bus(1'b1, tsctl_pkg::OFF_DEV_KEY, 32'h5A5A0001);
    bus(1'b1, tsctl_pkg::OFF_GRP_KEY2, 32'h00000010);
    bus(1'b1, tsctl_pkg::OFF_GRP_MASK2, 32'h000000FF);
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h0000A20C);
    rchk(tsctl_pkg::OFF_CFG, 32'h0000A20C);
    repeat (30) @(posedge clk);
    pkt(32'h5A5A0002, 32'h000000FF);
    pkt(32'h5A5A0001, 32'h00000F00);
    chk(n_act2, 0);
    chk(ts < 20, 1'b0);
    pkt(32'h5A5A0001, 32'h00000001);
    chk(n_act2, 1);
    chk(n_trig, 1);
    chk(ts < 12, 1'b1);
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h00002100);
    rchk(tsctl_pkg::OFF_CFG, 32'h00000100);
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h00001100);
    rchk(tsctl_pkg::OFF_CFG, 32'h00001100);
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h00002100);
    rchk(tsctl_pkg::OFF_CFG, 32'h00001100);
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h00001000);
    rchk(tsctl_pkg::OFF_CFG, 32'h00001000);
    bus(1'b1, tsctl_pkg::OFF_GRP_KEY1, 32'h00000010);
    bus(1'b1, tsctl_pkg::OFF_GRP_MASK1, 32'h00000001);
    bus(1'b1, tsctl_pkg::OFF_CFG, 32'h00005000);
    pkt(32'h5A5A0001, 32'h00000001);
    chk(n_act1, 1);
    chk(n_trig, 2);
    bus(1'b1, tsctl_pkg::OFF_EVT_CHOICE, 32'h5);
    bus(1'b1, tsctl_pkg::OFF_NOTIFY, 32'h1);
    bus(1'b1, tsctl_pkg::OFF_EVT_CHOICE, 32'h2);
    bus(1'b1, tsctl_pkg::OFF_NOTIFY, 32'h1);
    @(negedge clk) chk(nen, 16'h0024);
    bus(1'b1, tsctl_pkg::OFF_EVT_CHOICE, 32'h5);
    bus(1'b1, tsctl_pkg::OFF_NOTIFY, 32'h0);
    @(negedge clk) chk(nen, 16'h0004);
    rchk(tsctl_pkg::OFF_EVT_CHOICE, 32'h5);
    report_and_stop();
  end
endmodule // tsctl_top_tb
`default_nettype wire
